// [src/utc_consts.svh]
`ifndef UTC_CONSTS_SVH
`define UTC_CONSTS_SVH
`define UTC_CTRL_ADDR 8'hd7
`define UTC_CTRL_RESET 8'h00
`define UTC_BIT_PULLUP 7
`define UTC_BIT_XCVR_EN 6
`define UTC_BIT_SPEED 5
`define UTC_BIT_TEST_HI 4
`define UTC_BIT_TEST_LO 3
`define UTC_BIT_DIFF 2
`define UTC_BIT_POS 1
`define UTC_BIT_NEG 0
`define UTC_TEST_NORMAL 2'h0
`define UTC_TEST_DIFF1 2'h1
`define UTC_TEST_DIFF0 2'h2
`define UTC_TEST_SE0 2'h3
`endif

// [src/utc_pkg.sv]
package utc_pkg;
  typedef enum logic [1:0] {
    UTC_TM_NORMAL,
    UTC_TM_DIFF1,
    UTC_TM_DIFF0,
    UTC_TM_SE0
  } utc_test_mode_t;
endpackage

// [src/utc_sync2.sv]
`timescale 1ns/1ns
module utc_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic stage1;
  logic next_stage1;
  logic next_q;
  always_comb begin
    next_stage1 = d;
    next_q = stage1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      q <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end
endmodule // utc_sync2

// [src/utc_transceiver_config.sv]
// What this block does
// R1: transceiver_enable low suspends the transceiver; high makes it operate.
// R2: pullup_enable low detaches the pullup; high connects it per speed.
// R3: speed bit 1 means full speed, pullup on D+.
// R4: speed bit 0 means low speed, pullup on D-.
// R5: pullup connects only while VBUS is present.
// R6: test mode 00 normal, 01 D+ high, 10 D- high, 11 both low.
// R7: software should start the USB clock before enabling the transceiver.
// R8: read-only bits show differential receive state and both line levels.
`timescale 1ns/1ns
`include "utc_consts.svh"
module utc_transceiver_config (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  output logic [7:0] SFR_RDATA,
  input wire logic VBUS_PRESENT,
  input wire logic DP_IN,
  input wire logic DN_IN,
  output logic DP_OUT,
  output logic DP_OE,
  output logic DN_OUT,
  output logic DN_OE,
  output logic DP_PULLUP_EN,
  output logic DN_PULLUP_EN,
  output logic XCVR_SUSPEND,
  output logic FULL_SPEED
);
  logic pullup_enable;
  logic transceiver_enable;
  logic speed;
  utc_pkg::utc_test_mode_t transceiver_test_mode;
  logic next_pullup_enable;
  logic next_transceiver_enable;
  logic next_speed;
  utc_pkg::utc_test_mode_t next_test_mode;
  logic vbus_s;
  logic dp_s;
  logic dn_s;
  logic differential_receive_state;
  logic positive_line_level;
  logic negative_line_level;
  logic next_diff;
  logic pullup_on;
  logic [1:0] next_drive;
  logic next_dp_oe;
  logic [7:0] next_rdata;

  utc_sync2 u_sync_vbus (.clk(CLOCK), .rst(RST), .d(VBUS_PRESENT),
    .q(vbus_s));
  utc_sync2 u_sync_dp (.clk(CLOCK), .rst(RST), .d(DP_IN), .q(dp_s));
  utc_sync2 u_sync_dn (.clk(CLOCK), .rst(RST), .d(DN_IN), .q(dn_s));

  // control register; R7 ordering is left to software, no interlock
  always_comb begin
    next_pullup_enable = pullup_enable;
    next_transceiver_enable = transceiver_enable;
    next_speed = speed;
    next_test_mode = transceiver_test_mode;
    if (SFR_WR && SFR_ADDR == `UTC_CTRL_ADDR) begin
      next_pullup_enable = SFR_WDATA[`UTC_BIT_PULLUP];
      next_transceiver_enable = SFR_WDATA[`UTC_BIT_XCVR_EN];
      next_speed = SFR_WDATA[`UTC_BIT_SPEED];
      next_test_mode = utc_pkg::utc_test_mode_t'(
        SFR_WDATA[`UTC_BIT_TEST_HI:`UTC_BIT_TEST_LO]);
    end
  end

  // status: differential only refreshed while enabled, holds otherwise
  always_comb begin
    next_diff = differential_receive_state;
    if (transceiver_enable) begin
      next_diff = dp_s & ~dn_s; // [R8]
    end
  end

  assign pullup_on = pullup_enable & vbus_s; // [R2] [R5]

  always_comb begin
    next_dp_oe = 1'b1;
    next_drive = 2'b00;
    case (transceiver_test_mode) // [R6]
      utc_pkg::UTC_TM_NORMAL: begin
        next_dp_oe = 1'b0;
      end
      utc_pkg::UTC_TM_DIFF1: begin
        next_drive = 2'b10;
      end
      utc_pkg::UTC_TM_DIFF0: begin
        next_drive = 2'b01;
      end
      utc_pkg::UTC_TM_SE0: begin
        next_drive = 2'b00;
      end
      default: begin
        next_dp_oe = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_rdata = 8'h00;
    if (SFR_ADDR == `UTC_CTRL_ADDR) begin
      next_rdata[`UTC_BIT_PULLUP] = next_pullup_enable;
      next_rdata[`UTC_BIT_XCVR_EN] = next_transceiver_enable;
      next_rdata[`UTC_BIT_SPEED] = next_speed;
      next_rdata[`UTC_BIT_TEST_HI:`UTC_BIT_TEST_LO] = next_test_mode;
      next_rdata[`UTC_BIT_DIFF] = differential_receive_state; // [R8]
      next_rdata[`UTC_BIT_POS] = positive_line_level; // [R8]
      next_rdata[`UTC_BIT_NEG] = negative_line_level; // [R8]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pullup_enable <= 1'b0;
      transceiver_enable <= 1'b0;
      speed <= 1'b0;
      transceiver_test_mode <= utc_pkg::UTC_TM_NORMAL;
      differential_receive_state <= 1'b0;
      positive_line_level <= 1'b0;
      negative_line_level <= 1'b0;
      SFR_RDATA <= `UTC_CTRL_RESET;
      DP_OUT <= 1'b0;
      DN_OUT <= 1'b0;
      DP_OE <= 1'b0;
      DN_OE <= 1'b0;
      DP_PULLUP_EN <= 1'b0;
      DN_PULLUP_EN <= 1'b0;
      XCVR_SUSPEND <= 1'b1;
      FULL_SPEED <= 1'b0;
    end else begin
      pullup_enable <= next_pullup_enable;
      transceiver_enable <= next_transceiver_enable;
      speed <= next_speed;
      transceiver_test_mode <= next_test_mode;
      differential_receive_state <= next_diff;
      positive_line_level <= dp_s;
      negative_line_level <= dn_s;
      SFR_RDATA <= next_rdata;
      DP_OUT <= next_drive[1];
      DN_OUT <= next_drive[0];
      DP_OE <= next_dp_oe;
      DN_OE <= next_dp_oe;
      DP_PULLUP_EN <= pullup_on & speed; // [R3]
      DN_PULLUP_EN <= pullup_on & ~speed; // [R4]
      XCVR_SUSPEND <= ~transceiver_enable; // [R1]
      FULL_SPEED <= speed; // [R3] [R4]
    end
  end

  // every check below lives in the one clock domain and idles in reset
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // a control write lands at its own edge and reaches the pins one edge later
  sequence s_enable_write;
    SFR_WR && SFR_ADDR == `UTC_CTRL_ADDR && SFR_WDATA[`UTC_BIT_XCVR_EN];
  endsequence
  sequence s_disable_write;
    SFR_WR && SFR_ADDR == `UTC_CTRL_ADDR && !SFR_WDATA[`UTC_BIT_XCVR_EN];
  endsequence
  sequence s_operating;
    ##2 !XCVR_SUSPEND;
  endsequence
  sequence s_suspended;
    ##2 XCVR_SUSPEND;
  endsequence

  chk_suspend_follows: assert property ( // [R1]
    ##1 XCVR_SUSPEND == !$past(transceiver_enable))
    else $error("suspend does not follow enable");
  chk_enable_write: assert property ( // [R1]
    s_enable_write |-> s_operating)
    else $error("transceiver not operating after enable write");
  chk_disable_write: assert property ( // [R1]
    s_disable_write |-> s_suspended)
    else $error("transceiver not suspended after disable write");
  chk_pullup_detach: assert property ( // [R2]
    !pullup_enable |=> !DP_PULLUP_EN && !DN_PULLUP_EN)
    else $error("pullup on while disabled");
  chk_full_speed_dp: assert property ( // [R3]
    pullup_enable && vbus_s && speed |=> DP_PULLUP_EN && !DN_PULLUP_EN)
    else $error("full speed pullup not on D+");
  chk_speed_flag: assert property ( // [R3]
    ##1 FULL_SPEED == $past(speed))
    else $error("speed flag does not follow speed bit");
  chk_low_speed_dn: assert property ( // [R4]
    pullup_enable && vbus_s && !speed |=> DN_PULLUP_EN && !DP_PULLUP_EN)
    else $error("low speed pullup not on D-");
  chk_vbus_gate: assert property ( // [R5]
    !vbus_s |=> !DP_PULLUP_EN && !DN_PULLUP_EN)
    else $error("pullup on without VBUS");
  chk_test_diff1: assert property ( // [R6]
    transceiver_test_mode == utc_pkg::UTC_TM_DIFF1
    |=> DP_OE && DN_OE && DP_OUT && !DN_OUT)
    else $error("test mode 01 drive wrong");
  chk_test_diff0: assert property ( // [R6]
    transceiver_test_mode == utc_pkg::UTC_TM_DIFF0
    |=> DP_OE && DN_OE && !DP_OUT && DN_OUT)
    else $error("test mode 10 drive wrong");
  chk_test_se0: assert property ( // [R6]
    transceiver_test_mode == utc_pkg::UTC_TM_SE0
    |=> DP_OE && DN_OE && !DP_OUT && !DN_OUT)
    else $error("test mode 11 drive wrong");
  chk_test_normal: assert property ( // [R6]
    transceiver_test_mode == utc_pkg::UTC_TM_NORMAL |=> !DP_OE && !DN_OE)
    else $error("normal mode drives lines");

  // status side: levels are one stage behind the synchronisers
  chk_diff_hold: assert property ( // [R8]
    !transceiver_enable |=> $stable(differential_receive_state))
    else $error("differential changed while disabled");
  chk_diff_track: assert property ( // [R8]
    transceiver_enable && dp_s && !dn_s |=> differential_receive_state)
    else $error("differential one not captured");
  chk_diff_zero: assert property ( // [R8]
    transceiver_enable && !(dp_s && !dn_s) |=> !differential_receive_state)
    else $error("differential zero not captured");
  chk_line_levels: assert property ( // [R8]
    ##1 positive_line_level == $past(dp_s)
    && negative_line_level == $past(dn_s))
    else $error("line level status does not follow pins");
  chk_status_read: assert property ( // [R8]
    SFR_ADDR == `UTC_CTRL_ADDR |=> SFR_RDATA[`UTC_BIT_POS] ==
    $past(positive_line_level))
    else $error("read data does not show D+ level");
endmodule // utc_transceiver_config

// [test/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic clock = 0, rst = 1, wr_s = 0, vbus = 0, hd = 1, hdp = 0, hdn = 0;
  logic [7:0] addr = 8'hd7, wd = 8'h00, r = 8'h00, d;
  logic [7:0] rdata;
  wire [7:0] outs;
  logic dpl, dnl, diff = 0;
  int n_errors = 0, checked = 0, cyc = 0;
  initial forever #50 clock = ~clock;
  utc_transceiver_config dut (.CLOCK(clock), .RST(rst), .SFR_ADDR(addr),
    .SFR_WDATA(wd), .SFR_WR(wr_s), .SFR_RDATA(rdata), .VBUS_PRESENT(vbus),
    .DP_IN(dpl), .DN_IN(dnl), .DP_OUT(outs[7]), .DP_OE(outs[6]),
    .DN_OUT(outs[5]), .DN_OE(outs[4]), .DP_PULLUP_EN(outs[3]),
    .DN_PULLUP_EN(outs[2]), .XCVR_SUSPEND(outs[1]), .FULL_SPEED(outs[0]));
  utc_host_model host (.dp_oe(outs[6]), .dp_out(outs[7]), .dn_oe(outs[4]),
    .dn_out(outs[5]), .dp_pu(outs[3]), .dn_pu(outs[2]), .drive(hd),
    .drv_dp(hdp), .drv_dn(hdn), .dp_line(dpl), .dn_line(dnl));
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [1:0] lines();
    logic [1:0] tm;
    tm = r[4:3];
    if (tm != 2'h0) return {tm == 2'h1, tm == 2'h2};
    if (hd) return {hdp, hdn};
    return {r[7] & vbus & r[5], r[7] & vbus & ~r[5]};
  endfunction
  // looks half a period after the edge, so registered outputs have settled
  task automatic check();
    logic [1:0] tm;
    logic [7:0] e;
    @(negedge clock);
    tm = r[4:3];
    e = {tm == 2'h1, tm != 2'h0, tm == 2'h2, tm != 2'h0,
      r[7] & vbus & r[5], r[7] & vbus & ~r[5], ~r[6], r[5]};
    cmp("outputs", e, outs);
    cmp("status", {r[7:3], diff, lines()}, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wd <= v;
    wr_s <= 1;
    @(posedge clock);
    wr_s <= 0;
    addr <= 8'hd7;
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'hb9d977b8));
    repeat (3) @(posedge clock);
    rst <= 0;
    repeat (5) @(posedge clock);
    check();
    $display("reset test done");
    // one clock serves the usb side too, so it runs before any enable
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      {hd, hdp, hdn, vbus} <= 4'($urandom);
      repeat (6) @(posedge clock);
      if (r[6]) diff = lines() == 2'h2;
      d = 8'($urandom);
      if (i < 4) d[4:3] = 2'(i);
      wr(8'hd7, d);
      r = d & 8'hf8;
      repeat (6) @(posedge clock);
      if (r[6]) diff = lines() == 2'h2;
      check();
    end
    $display("random test done");
    // reset again in mid-run: everything returns to its reset state
    @(posedge clock);
    rst <= 1;
    repeat (3) @(posedge clock);
    rst <= 0;
    r = 8'h00;
    diff = 0;
    repeat (5) @(posedge clock);
    check();
    $display("mid reset test done");
    // a known non-zero register makes the ignored write and read visible
    wr(8'hd7, 8'h40);
    r = 8'h40;
    wr(8'hd6, 8'hff);
    repeat (6) @(posedge clock);
    diff = lines() == 2'h2;
    check();
    @(posedge clock);
    addr <= 8'hd6;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp("other_read", 8'h00, rdata);
    $display("address test done");
    stop_test();
  end
endmodule // testbench

// [test/utc_host_model.sv]
`timescale 1ns/1ns
module utc_host_model (
  input wire logic dp_oe,
  input wire logic dp_out,
  input wire logic dn_oe,
  input wire logic dn_out,
  input wire logic dp_pu,
  input wire logic dn_pu,
  input wire logic drive,
  input wire logic drv_dp,
  input wire logic drv_dn,
  output logic dp_line,
  output logic dn_line
);
  // host pulldowns hold an undriven line low unless the device pullup wins
  assign dp_line = dp_oe ? dp_out : drive ? drv_dp : dp_pu;
  assign dn_line = dn_oe ? dn_out : drive ? drv_dn : dn_pu;
endmodule // utc_host_model
